// ---- verilog/flash_self_program_guard.sv ----
// Purpose: access control and stall logic for flash self-programming
// Assumes: cpu gives pc and target address with each request
// Notes: lock bits return to unprogrammed on reset as well as on chip erase
// How it works
// - stores fetched from application region are ignored
// - stores from boot region may target any flash page
// - concurrent region programming leaves cpu running on stall region
// - stall region programming halts cpu; no flash reads allowed
// - busy flag reads one while concurrent region is blocked
// - busy flag and block stay until software clears them
// - boot region always lies inside the stall region
// - boot boundary from fuses; stall boundary fixed
// - locks programmed by software or programmer; chip erase restores
// - general write lock does not affect self-programming stores
// - general read/write lock never restricts loads or stores
// - both app locks unprogrammed allow full access to application
// - app write lock programmed refuses stores to application
// - app read lock blocks boot-run loads from application
// - app read lock with boot vectors masks interrupts in app code
// - both boot locks unprogrammed allow full access to boot region
// - boot write lock programmed refuses stores to boot region
// - boot read lock blocks app-run loads from boot region
// - boot read lock with app vectors masks interrupts in boot code
`timescale 1ns/100ps
`include "flash_guard_map.svh"
module flash_self_program_guard #(
   parameter int ADDR_W = 15,
   parameter int STALL_REGION_WORDS = 4096,
   parameter int BOOT_MIN_WORDS = 512,
   parameter int PROG_CYCLES = `FG_PROG_CYCLES
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   // wishbone classic slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // cpu request side
   input wire logic [ADDR_W-1:0] PC_I,
   input wire logic STORE_REQ_I,
   input wire logic STORE_ERASE_I,
   input wire logic [ADDR_W-1:0] STORE_ADDR_I,
   input wire logic LOAD_REQ_I,
   input wire logic [ADDR_W-1:0] LOAD_ADDR_I,
   output logic LOAD_ALLOW_O,
   output logic CPU_HALT_O,
   output logic IRQ_MASK_O,
   // flash array side
   output logic FLASH_START_O,
   output logic FLASH_ERASE_O,
   output logic [ADDR_W-1:0] FLASH_ADDR_O,
   input wire logic FLASH_DONE_I,
   // fuses, general lock mode, chip erase and external lock programming
   input wire logic [1:0] BOOT_SIZE_FUSES_I,
   input wire logic [1:0] GENERAL_LOCK_MODE_I,
   input wire logic CHIP_ERASE_I,
   input wire logic [3:0] EXT_LOCK_PROGRAM_I
);

   flash_guard_pkg::prog_state_type state;
   flash_guard_pkg::prog_state_type next_state;
   flash_guard_pkg::lock_set_type locks;
   logic busy;
   logic in_stall_op;
   logic ivec_boot;
   logic refused;
   logic [ADDR_W-1:0] op_addr;
   logic op_erase;
   logic [15:0] timer;

   wire logic pc_boot;
   wire logic pc_stall;
   wire logic st_boot;
   wire logic st_stall;
   wire logic ld_boot;
   wire logic ld_stall;
   wire logic store_write_ok;
   wire logic store_go;
   wire logic store_refuse;
   wire logic load_lock_ok;
   wire logic op_finish;
   wire logic [3:0] lock_vec;
   wire logic [3:0] sw_lock_prog;

   region_decode #(
      .ADDR_W(ADDR_W),
      .STALL_REGION_WORDS(STALL_REGION_WORDS),
      .BOOT_MIN_WORDS(BOOT_MIN_WORDS)
   ) u_pc_dec (
      .addr_i(PC_I),
      .boot_size_fuses_i(BOOT_SIZE_FUSES_I),
      .in_boot_o(pc_boot),
      .in_stall_o(pc_stall)
   );

   region_decode #(
      .ADDR_W(ADDR_W),
      .STALL_REGION_WORDS(STALL_REGION_WORDS),
      .BOOT_MIN_WORDS(BOOT_MIN_WORDS)
   ) u_st_dec (
      .addr_i(STORE_ADDR_I),
      .boot_size_fuses_i(BOOT_SIZE_FUSES_I),
      .in_boot_o(st_boot),
      .in_stall_o(st_stall)
   );

   region_decode #(
      .ADDR_W(ADDR_W),
      .STALL_REGION_WORDS(STALL_REGION_WORDS),
      .BOOT_MIN_WORDS(BOOT_MIN_WORDS)
   ) u_ld_dec (
      .addr_i(LOAD_ADDR_I),
      .boot_size_fuses_i(BOOT_SIZE_FUSES_I),
      .in_boot_o(ld_boot),
      .in_stall_o(ld_stall)
   );

   // ---------------- register bus ----------------
   wire logic bus_req;
   wire logic bus_wr;
   wire logic wr_ctrl;
   wire logic wr_lock;
   wire logic [31:0] rd_mux;

   assign bus_req = CYC_I & STB_I & ~ACK_O;
   assign bus_wr = bus_req & WE_I & SEL_I[0];
   assign wr_ctrl = bus_wr & (ADR_I == `FG_CTRL_OFS);
   assign wr_lock = bus_wr & (ADR_I == `FG_LOCK_OFS);

   // with FG_LK_SET high, writing zero to a lock field programs it; one leaves it alone
   assign sw_lock_prog = {4{wr_lock & DAT_I[`FG_LK_SET]}} &
      ~DAT_I[3:0];

   assign rd_mux =
      (ADR_I == `FG_CTRL_OFS) ?
         {30'h0, ivec_boot, 1'b0} :
      (ADR_I == `FG_STATUS_OFS) ?
         {28'h0, refused, (state == flash_guard_pkg::ST_PROG),
          CPU_HALT_O, busy} :
      (ADR_I == `FG_LOCK_OFS) ? {28'h0, lock_vec} :
      (ADR_I == `FG_FUSE_OFS) ? {30'h0, BOOT_SIZE_FUSES_I} :
      32'h0;

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         ACK_O <= 1'b0;
         DAT_O <= 32'h0;
      end else begin
         ACK_O <= bus_req;
         DAT_O <= bus_req ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I)
         ivec_boot <= 1'b0;
      else if (wr_ctrl)
         ivec_boot <= DAT_I[`FG_CTRL_IVEC_BOOT];
   end

   // ---------------- lock bits ----------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lock
         lock_cell u_cell (
            .clk_i(CORE_CLK_I),
            .rst_i(RST_I),
            .program_i(sw_lock_prog[gi] | EXT_LOCK_PROGRAM_I[gi]),
            .chip_erase_i(CHIP_ERASE_I),
            .value_o(lock_vec[gi])
         );
      end
   endgenerate

   assign locks.app_write_lock = lock_vec[`FG_LK_APP_W];
   assign locks.app_read_lock = lock_vec[`FG_LK_APP_R];
   assign locks.boot_write_lock = lock_vec[`FG_LK_BOOT_W];
   assign locks.boot_read_lock = lock_vec[`FG_LK_BOOT_R];

   // ---------------- store checks ----------------
   // general lock mode is deliberately not consulted here
   assign store_write_ok = st_boot ? locks.boot_write_lock
      : locks.app_write_lock;
   // only boot-resident code may start programming, anywhere in flash
   assign store_go = STORE_REQ_I & pc_boot & store_write_ok &
      (state == flash_guard_pkg::ST_IDLE);
   assign store_refuse = STORE_REQ_I & ~store_go;

   // ---------------- programming sequence ----------------
   assign op_finish = FLASH_DONE_I | (timer == 16'h0001);

   always_comb begin
      next_state = state;
      unique case (state)
         flash_guard_pkg::ST_IDLE:
            if (store_go)
               next_state = flash_guard_pkg::ST_PROG;
         flash_guard_pkg::ST_PROG:
            if (op_finish)
               next_state = flash_guard_pkg::ST_DONE;
         flash_guard_pkg::ST_DONE:
            next_state = flash_guard_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         state <= flash_guard_pkg::ST_IDLE;
         op_addr <= '0;
         op_erase <= 1'b0;
         in_stall_op <= 1'b0;
         timer <= 16'h0000;
      end else begin
         state <= next_state;
         if (store_go) begin
            op_addr <= STORE_ADDR_I;
            op_erase <= STORE_ERASE_I;
            in_stall_op <= st_stall;
            timer <= 16'(PROG_CYCLES);
         end else if (timer != 16'h0000) begin
            timer <= timer - 16'h0001;
         end
      end
   end

   // ---------------- busy flag ----------------
   // set wins over a same-cycle software clear
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I)
         busy <= 1'b0;
      else if (store_go & ~st_stall)
         busy <= 1'b1;
      else if (wr_ctrl & DAT_I[`FG_CTRL_CLR_BUSY] &
               (state == flash_guard_pkg::ST_IDLE))
         busy <= 1'b0;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I)
         refused <= 1'b0;
      else if (store_refuse)
         refused <= 1'b1;
      else if (wr_ctrl & DAT_I[`FG_CTRL_CLR_BUSY])
         refused <= 1'b0;
   end

   // ---------------- outputs ----------------
   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         FLASH_START_O <= 1'b0;
         FLASH_ERASE_O <= 1'b0;
         FLASH_ADDR_O <= '0;
      end else begin
         FLASH_START_O <= store_go;
         FLASH_ERASE_O <= store_go & STORE_ERASE_I;
         FLASH_ADDR_O <= store_go ? STORE_ADDR_I : op_addr;
      end
   end

   assign CPU_HALT_O = (state == flash_guard_pkg::ST_PROG) &
      in_stall_op;

   // cross-region read locks, then region availability
   assign load_lock_ok =
      (pc_boot & ~ld_boot) ? locks.app_read_lock :
      (~pc_boot & ld_boot) ? locks.boot_read_lock :
      1'b1;
   // concurrent region readable only while not blocked
   assign LOAD_ALLOW_O = LOAD_REQ_I & load_lock_ok & ~CPU_HALT_O &
      (ld_stall | ~busy);

   assign IRQ_MASK_O =
      (~pc_boot & ~locks.app_read_lock & ivec_boot) |
      (pc_boot & ~locks.boot_read_lock & ~ivec_boot);

   wire logic unused_ok;
   assign unused_ok = &{1'b0, GENERAL_LOCK_MODE_I, pc_stall, op_erase,
      SEL_I[3:1], DAT_I[31:5]};
endmodule

// ---- verilog/flash_guard_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: word-addressed flash, 32-bit wishbone register words
// Notes: included by the design files only
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

// register byte offsets
`define FG_CTRL_OFS 8'h00
`define FG_STATUS_OFS 8'h04
`define FG_LOCK_OFS 8'h08
`define FG_FUSE_OFS 8'h0C

// ctrl fields
`define FG_CTRL_CLR_BUSY 0
`define FG_CTRL_IVEC_BOOT 1
// status fields
`define FG_ST_BUSY 0
`define FG_ST_HALT 1
`define FG_ST_ACTIVE 2
`define FG_ST_REFUSED 3
// lock fields: app write, app read, boot write, boot read
`define FG_LK_APP_W 0
`define FG_LK_APP_R 1
`define FG_LK_BOOT_W 2
`define FG_LK_BOOT_R 3
`define FG_LK_SET 4

// lock bits unprogrammed after reset and chip erase
`define FG_LOCK_RESET 4'hF

// default programming time, in us, and derived cycle count
`define FG_PROG_TIME_US 4
`define FG_CLK_MHZ 200
`define FG_PROG_CYCLES (`FG_PROG_TIME_US * `FG_CLK_MHZ)

`endif

// ---- verilog/flash_guard_pkg.sv ----
// Purpose: shared types for the flash self-program guard
// Assumes: nothing beyond the map header
// Notes: constants stay in the map header
package flash_guard_pkg;

   typedef struct packed {
      logic app_write_lock;
      logic app_read_lock;
      logic boot_write_lock;
      logic boot_read_lock;
   } lock_set_type;

   typedef enum logic [1:0] {
      OP_NONE,
      OP_ERASE,
      OP_WRITE
   } prog_op_type;

   typedef enum {
      ST_IDLE,
      ST_PROG,
      ST_DONE
   } prog_state_type;

endpackage

// ---- verilog/region_decode.sv ----
// Purpose: classifies one flash word address into its regions
// Assumes: boot region sits at the top of flash
// Notes: boot size comes from the fuse code, largest at code 0
`timescale 1ns/100ps
module region_decode #(
   parameter int ADDR_W = 15,
   parameter int STALL_REGION_WORDS = 4096,
   parameter int BOOT_MIN_WORDS = 512
) (
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [1:0] boot_size_fuses_i,
   output logic in_boot_o,
   output logic in_stall_o
);
   localparam int FLASH_WORDS = 1 << ADDR_W;
   localparam logic [ADDR_W-1:0] STALL_REGION_BASE =
      ADDR_W'(FLASH_WORDS - STALL_REGION_WORDS);

   wire logic [ADDR_W:0] boot_words;
   wire logic [ADDR_W-1:0] boot_base;
   wire logic [ADDR_W-1:0] clamped_base;

   // code 3 smallest, each lower code doubles
   assign boot_words = (ADDR_W+1)'(BOOT_MIN_WORDS)
      << (2'h3 - boot_size_fuses_i);
   assign boot_base = ADDR_W'((ADDR_W+1)'(FLASH_WORDS) - boot_words);
   // never let boot reach below the fixed stall boundary
   assign clamped_base = (boot_base < STALL_REGION_BASE) ? STALL_REGION_BASE :
      boot_base;
   assign in_boot_o = (addr_i >= clamped_base);
   assign in_stall_o = (addr_i >= STALL_REGION_BASE);
endmodule

// ---- verilog/lock_cell.sv ----
// Purpose: one lock bit, programmable to zero, restored by chip erase
// Assumes: programming only lowers the bit
// Notes: one instance per lock bit
`timescale 1ns/100ps
module lock_cell (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic program_i,
   input wire logic chip_erase_i,
   output logic value_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i)
         value_o <= 1'b1;
      else if (chip_erase_i)
         value_o <= 1'b1;
      else if (program_i)
         value_o <= 1'b0;
   end
endmodule

// ---- bench/flash_self_program_guard_monitor.sv ----
// Purpose: concurrent checks on the guard's cpu and flash ports
// Assumes: boot region at the top, stall region the top STALL_REGION_WORDS
// Notes: bound into every guard instance
`timescale 1ns/100ps
module flash_self_program_guard_monitor #(
   parameter int ADDR_W = 15,
   parameter int STALL_REGION_WORDS = 4096,
   parameter int BOOT_MIN_WORDS = 512,
   parameter int PROG_CYCLES = 800
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic CYC_I,
   input wire logic [ADDR_W-1:0] PC_I,
   input wire logic STORE_REQ_I,
   input wire logic LOAD_REQ_I,
   input wire logic [ADDR_W-1:0] LOAD_ADDR_I,
   input wire logic LOAD_ALLOW_O,
   input wire logic CPU_HALT_O,
   input wire logic FLASH_START_O,
   input wire logic [ADDR_W-1:0] FLASH_ADDR_O,
   input wire logic FLASH_DONE_I,
   input wire logic [1:0] BOOT_SIZE_FUSES_I
);
   localparam int STALL = 2**ADDR_W - STALL_REGION_WORDS;
   // margin: the timeout's exact cycle is the design's choice
   localparam int HOLD = PROG_CYCLES - 3;
   wire pc_boot = PC_I >=
      2**ADDR_W - (BOOT_MIN_WORDS << (3 - BOOT_SIZE_FUSES_I));
   wire stall_tgt = FLASH_ADDR_O >= STALL;
   wire ld_rww = LOAD_REQ_I && LOAD_ADDR_I < STALL;
   logic rww_op;
   int hcnt;
   always_ff @(posedge CORE_CLK_I) begin
      rww_op <= RST_I ? 1'b0 : FLASH_START_O ? !stall_tgt : rww_op;
      hcnt <= (RST_I || !CPU_HALT_O) ? 0 : hcnt + 1;
   end
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   a_app_store_ignored: assert property (
      STORE_REQ_I && !pc_boot |=> !FLASH_START_O) else $error("app store");
   a_start_pulse: assert property (
      FLASH_START_O |=> !FLASH_START_O) else $error("long start");
   a_stall_halts: assert property (
      FLASH_START_O && stall_tgt |-> CPU_HALT_O) else $error("no halt");
   a_rww_runs: assert property (
      FLASH_START_O && !stall_tgt |-> !CPU_HALT_O) else $error("halted");
   a_halt_no_load: assert property (
      CPU_HALT_O && LOAD_REQ_I |-> !LOAD_ALLOW_O) else $error("halt load");
   a_halt_held: assert property (
      CPU_HALT_O && !FLASH_DONE_I && hcnt < HOLD |=> CPU_HALT_O)
      else $error("halt dropped");
   a_busy_blocks: assert property (
      FLASH_START_O && !stall_tgt ##1 ld_rww |-> !LOAD_ALLOW_O)
      else $error("busy load");
   a_busy_sticks: assert property (
      rww_op && FLASH_DONE_I && !CYC_I ##1 ld_rww && !CYC_I
      |-> !LOAD_ALLOW_O) else $error("busy lost");
   c_stall_op: cover property (FLASH_START_O && stall_tgt);
   c_rww_op: cover property (FLASH_START_O && !stall_tgt);
   c_refused: cover property (STORE_REQ_I && !pc_boot);
endmodule

bind flash_self_program_guard flash_self_program_guard_monitor #(
   .ADDR_W(ADDR_W), .STALL_REGION_WORDS(STALL_REGION_WORDS),
   .BOOT_MIN_WORDS(BOOT_MIN_WORDS), .PROG_CYCLES(PROG_CYCLES)
) mon (
   .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CYC_I(CYC_I), .PC_I(PC_I),
   .STORE_REQ_I(STORE_REQ_I), .LOAD_REQ_I(LOAD_REQ_I),
   .LOAD_ADDR_I(LOAD_ADDR_I), .LOAD_ALLOW_O(LOAD_ALLOW_O),
   .CPU_HALT_O(CPU_HALT_O), .FLASH_START_O(FLASH_START_O),
   .FLASH_ADDR_O(FLASH_ADDR_O), .FLASH_DONE_I(FLASH_DONE_I),
   .BOOT_SIZE_FUSES_I(BOOT_SIZE_FUSES_I)
);

// ---- bench/flash_array_model.sv ----
// Purpose: flash array stand-in answering each started operation whose lat_i is nonzero
// Assumes: lat_i of zero means the array never reports done
// Notes: done only ever follows a start
`timescale 1ns/100ps
module flash_array_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [7:0] lat_i,
   output logic done_o
);
   int cnt;
   initial done_o = 1'b0;
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i || start_i) begin
         cnt <= rst_i ? 0 : int'(lat_i);
      end else if (cnt == 1) begin
         done_o <= 1'b1;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ---- bench/flash_self_program_guard_bench.sv ----
// Purpose: self-checking bench for the flash self-program guard
// Assumes: short programming timeout; array answers or stays mute
// Notes: expectations come from the region and lock model below
`timescale 1ns/100ps
module flash_self_program_guard_bench;
   localparam int PROG = 20;
   logic clk, rst, cyc, we, ack, req, er, lreq, allow, hlt, irq;
   logic start, fer, done, ce;
   logic [7:0] adr, lat;
   logic [31:0] wd, rdat, d;
   logic [14:0] pc, sa, la, fa;
   logic [1:0] fuse, gm;
   logic [3:0] ext;
   int seed = 32'h19b0a703;
   int fails, checks_done, base;
   bit [3:0] lk;
   bit ivb, busy, halt;
   bit [3:0] tbl [4] = '{4'hF, 4'hA, 4'h0, 4'h5};
   flash_self_program_guard #(.PROG_CYCLES(PROG)) uut (
      .CORE_CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(cyc),
      .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wd), .DAT_O(rdat),
      .ACK_O(ack), .PC_I(pc), .STORE_REQ_I(req), .STORE_ERASE_I(er),
      .STORE_ADDR_I(sa), .LOAD_REQ_I(lreq), .LOAD_ADDR_I(la),
      .LOAD_ALLOW_O(allow), .CPU_HALT_O(hlt), .IRQ_MASK_O(irq),
      .FLASH_START_O(start), .FLASH_ERASE_O(fer), .FLASH_ADDR_O(fa),
      .FLASH_DONE_I(done), .BOOT_SIZE_FUSES_I(fuse),
      .GENERAL_LOCK_MODE_I(gm), .CHIP_ERASE_I(ce),
      .EXT_LOCK_PROGRAM_I(ext)
   );
   flash_array_model flash (.clk_i(clk), .rst_i(rst), .start_i(start),
      .lat_i(lat), .done_o(done));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic bit inb(int a);
      return a >= 32768 - (512 << (3 - fuse));
   endfunction
   task automatic chk(logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic bus(bit w, logic [7:0] a, logic [31:0] v);
      int n;
      @(posedge clk);
      cyc <= 1'b1; we <= w; adr <= a; wd <= v;
      n = 0;
      // values read right after the edge are those sampled at it
      do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) fails++;
      d = rdat;
      cyc <= 1'b0;
   endtask
   task automatic ld(int p, int a);
      bit e, m;
      e = !halt && !(busy && a < 28672) && !(inb(p) && !inb(a) && !lk[1])
         && !(!inb(p) && inb(a) && !lk[3]);
      m = (!lk[1] && ivb && !inb(p)) || (!lk[3] && !ivb && inb(p));
      @(posedge clk);
      pc <= p; la <= a; lreq <= 1'b1;
      @(negedge clk);
      chk({e, m}, {allow, irq});
   endtask
   task automatic store(int p, int a, bit e);
      bit ok;
      ok = inb(p) && (inb(a) ? lk[2] : lk[0]);
      @(posedge clk);
      pc <= p; sa <= a; er <= e; req <= 1'b1; gm <= 2'($random(seed));
      @(posedge clk);
      req <= 1'b0;
      @(negedge clk);
      halt = ok && a >= 28672;
      busy = busy || (ok && !halt);
      chk({ok, halt}, {start, hlt});
      if (ok) chk({e, a[14:0]}, {fer, fa});
      ld(p, 15'h7000);
      ld(p, 15'h0100);
      repeat (PROG + 4) @(posedge clk);
      halt = 0;
      ld(p, 15'h0100);
      bus(0, 8'h04, 0);
      chk({!ok, 2'b00, busy}, d);
      bus(1, 8'h00, {ivb, 1'b1});
      busy = 0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      rst = 1'b1; {cyc, we, req, er, lreq, ce} = '0; adr = 0; wd = 0;
      pc = 0; sa = 0; la = 0; fuse = 2'h3; gm = 0; ext = 0; lat = 8'h02;
      lk = 4'hF;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(0, 8'h08, 0);
      chk(32'hF, d);
      bus(1, 8'h40, 32'hFFFF_FFFF);
      bus(0, 8'h40, 0);
      chk(0, d);
      for (int f = 0; f < 4; f++) begin
         fuse <= f[1:0];
         base = 32768 - (512 << (3 - f));
         bus(0, 8'h0C, 0);
         chk(f, d);
         store(base - 1, 15'h1000, 1'b0);
         store(base, base, 1'b1);
         store(base, 15'h1000 + (f << 6), 1'b0);
      end
      for (int i = 0; i < 4; i++) begin
         lat <= (i % 2) ? 8'h00 : 8'h02;
         @(posedge clk); ce <= 1'b1;
         @(posedge clk); ce <= 1'b0; ext <= (i % 2) ? ~tbl[i] : 4'h0;
         @(posedge clk); ext <= 4'h0;
         lk = tbl[i];
         if (i % 2 == 0) bus(1, 8'h08, {27'h0, 1'b1, tbl[i]});
         bus(1, 8'h08, 32'h1F);
         bus(0, 8'h08, 0);
         chk(tbl[i], d);
         for (int v = 0; v < 2; v++) begin
            ivb = v[0];
            bus(1, 8'h00, {ivb, 1'b0});
            store(32'h7F00, 15'h1000 + (i << 4), v[0]);
            store(32'h7F00, 15'h7F80, 1'b0);
            ld(32'h7F00, 15'h0100);
            ld(32'h0100, 15'h7F80);
         end
      end
      close_out;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      close_out;
   end
endmodule
